// ==== design/dsl_edge_sync.sv ====
// two-stage synchroniser with rising edge detect
`timescale 1ns/1ps
module dsl_edge_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b_sync,
  // asynchronous input
  input wire logic din,
  // synchronised level and edge
  output logic level,
  output logic rise
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  logic meta_d;
  logic sync_d;
  logic last_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge clk or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~last_q;
endmodule

// ==== design/dsl_loader.sv ====
// serial shift register and four programming latches of the synthesizer
`timescale 1ns/1ps
module dsl_loader (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // three-wire serial link
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  // lock indications from the loops
  input wire logic ch1_lock,
  input wire logic ch2_lock,
  // monitor pin, open drain
  output logic monitor_output_o,
  output logic monitor_output_oe_b,
  // channel one controls
  output logic [dsl_pkg::REF_W-1:0] ch1_ref_div,
  output logic [dsl_pkg::BASE_W-1:0] ch1_base_count,
  output logic [dsl_pkg::SWAL_W-1:0] ch1_swallow_count,
  output logic [dsl_pkg::FB_W-1:0] ch1_feedback_ratio,
  output logic ch1_prescaler_select,
  output logic ch1_power_down,
  output logic ch1_pump_tristate,
  output logic ch1_pump_gain,
  output logic ch1_detector_polarity,
  // channel two controls
  output logic [dsl_pkg::REF_W-1:0] ch2_ref_div,
  output logic [dsl_pkg::BASE_W-1:0] ch2_base_count,
  output logic [dsl_pkg::SWAL_W-1:0] ch2_swallow_count,
  output logic [dsl_pkg::FB_W-1:0] ch2_feedback_ratio,
  output logic ch2_prescaler_select,
  output logic ch2_power_down,
  output logic ch2_pump_tristate,
  output logic ch2_pump_gain,
  output logic ch2_detector_polarity
);
  import dsl_pkg::*;

  // --------------------------------------------------------------------
  // reset release and input synchronisers
  // --------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_b_sync;
  logic sclk_rise;
  logic le_rise;
  logic sdata_lvl;
  logic lock1_lvl;
  logic lock2_lvl;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_b_sync = rst_sync_q[1];

  dsl_edge_sync u_sclk (.clk(clk), .rst_b_sync(rst_b_sync),
    .din(serial_clk), .level(), .rise(sclk_rise));
  dsl_edge_sync u_sdat (.clk(clk), .rst_b_sync(rst_b_sync),
    .din(serial_data), .level(sdata_lvl), .rise());
  dsl_edge_sync u_le (.clk(clk), .rst_b_sync(rst_b_sync),
    .din(load_strobe), .level(), .rise(le_rise));
  dsl_edge_sync u_lk1 (.clk(clk), .rst_b_sync(rst_b_sync),
    .din(ch1_lock), .level(lock1_lvl), .rise());
  dsl_edge_sync u_lk2 (.clk(clk), .rst_b_sync(rst_b_sync),
    .din(ch2_lock), .level(lock2_lvl), .rise());

  // --------------------------------------------------------------------
  // shift register and latches
  // --------------------------------------------------------------------
  logic [WORD_W-1:0] shift_q, shift_d;
  logic [WORD_W-1:0] ch2_ref_q, ch2_ref_d;
  logic [WORD_W-1:0] ch2_fb_q, ch2_fb_d;
  logic [WORD_W-1:0] ch1_ref_q, ch1_ref_d;
  logic [WORD_W-1:0] ch1_fb_q, ch1_fb_d;
  dsl_sel_e sel;

  // drop select and unused bits so they never reach the controls
  function automatic logic [WORD_W-1:0] ref_mask(
      input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] m;
    m = w;
    m[16] = 1'b0; // RULE17
    m[1:0] = 2'b00;
    return m;
  endfunction

  function automatic logic [WORD_W-1:0] fb_mask(
      input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] m;
    m = w;
    m[8] = 1'b0; // RULE17
    m[1:0] = 2'b00;
    return m;
  endfunction

  // 17-bit feedback ratio, prescaler modulus times base plus swallow
  function automatic logic [FB_W-1:0] fb_ratio(
      input logic [WORD_W-1:0] w);
    logic [FB_W-1:0] p;
    logic [FB_W-1:0] b;
    logic [FB_W-1:0] a;
    p = {10'h000, (w[FB_PRESC] ? PRESC_64 : PRESC_32)}; // RULE14
    b = {6'h00, w[FB_BASE_MSB:FB_BASE_LSB]};
    a = {11'h000, w[FB_SWAL_MSB:FIELD_LSB]};
    return FB_W'(p * b + a); // RULE12
  endfunction

  assign sel = dsl_sel_e'(shift_q[1:0]); // RULE4

  always_comb begin
    shift_d = shift_q;
    ch2_ref_d = ch2_ref_q;
    ch2_fb_d = ch2_fb_q;
    ch1_ref_d = ch1_ref_q;
    ch1_fb_d = ch1_fb_q;
    if (sclk_rise) begin
      shift_d = {shift_q[WORD_W-2:0], sdata_lvl}; // RULE1
    end
    if (le_rise) begin // RULE3 RULE16
      case (sel) // RULE5
        DSL_CH2_REF: ch2_ref_d = ref_mask(shift_q); // RULE6
        DSL_CH2_FB: ch2_fb_d = fb_mask(shift_q); // RULE8
        DSL_CH1_REF: ch1_ref_d = ref_mask(shift_q); // RULE7
        DSL_CH1_FB: ch1_fb_d = fb_mask(shift_q); // RULE9
        default: ch2_ref_d = ch2_ref_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      shift_q <= LATCH_RST;
      ch2_ref_q <= LATCH_RST;
      ch2_fb_q <= LATCH_RST;
      ch1_ref_q <= LATCH_RST;
      ch1_fb_q <= LATCH_RST;
    end else begin
      shift_q <= shift_d;
      ch2_ref_q <= ch2_ref_d;
      ch2_fb_q <= ch2_fb_d;
      ch1_ref_q <= ch1_ref_d;
      ch1_fb_q <= ch1_fb_d;
    end
  end

  // --------------------------------------------------------------------
  // registered control outputs and monitor pin
  // --------------------------------------------------------------------
  logic [3:0] mon_sel;
  logic mon_low_d, mon_oe_b_d, mon_oe_b_q;
  logic [FB_W-1:0] r1_d, r2_d, r1_q, r2_q;

  assign mon_sel = {ch2_ref_q[REF_MON_HI], ch2_ref_q[REF_MON_LO],
                    ch1_ref_q[REF_MON_HI], ch1_ref_q[REF_MON_LO]}; // RULE10

  always_comb begin
    r1_d = fb_ratio(ch1_fb_q);
    r2_d = fb_ratio(ch2_fb_q);
    // open drain: pull low unless the selected source reads high
    case (mon_sel[3:2])
      MON_CH2_LOCK: mon_low_d = ~lock2_lvl; // RULE11
      2'b10: mon_low_d = ~lock1_lvl;
      2'b11: mon_low_d = ~(lock1_lvl & lock2_lvl);
      default: mon_low_d = 1'b1;
    endcase
    if (mon_sel[1:0] != 2'b00) begin
      mon_low_d = ~(lock1_lvl & lock2_lvl); // RULE10
    end
    mon_oe_b_d = ~mon_low_d;
  end

  always_ff @(posedge clk or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      mon_oe_b_q <= 1'b0;
      r1_q <= '0;
      r2_q <= '0;
    end else begin
      mon_oe_b_q <= mon_oe_b_d;
      r1_q <= r1_d;
      r2_q <= r2_d;
    end
  end

  assign monitor_output_o = 1'b0;
  assign monitor_output_oe_b = mon_oe_b_q; // RULE11
  assign ch1_feedback_ratio = r1_q;
  assign ch2_feedback_ratio = r2_q;
  assign ch1_ref_div = ch1_ref_q[REF_DIV_MSB:FIELD_LSB]; // RULE12
  assign ch2_ref_div = ch2_ref_q[REF_DIV_MSB:FIELD_LSB];
  assign ch1_base_count = ch1_fb_q[FB_BASE_MSB:FB_BASE_LSB];
  assign ch2_base_count = ch2_fb_q[FB_BASE_MSB:FB_BASE_LSB];
  assign ch1_swallow_count = ch1_fb_q[FB_SWAL_MSB:FIELD_LSB];
  assign ch2_swallow_count = ch2_fb_q[FB_SWAL_MSB:FIELD_LSB];
  assign ch1_prescaler_select = ch1_fb_q[FB_PRESC];
  assign ch2_prescaler_select = ch2_fb_q[FB_PRESC];
  assign ch1_power_down = ch1_fb_q[FB_PWRDN];
  assign ch2_power_down = ch2_fb_q[FB_PWRDN];
  assign ch1_pump_tristate = ch1_ref_q[REF_TRI];
  assign ch2_pump_tristate = ch2_ref_q[REF_TRI];
  assign ch1_pump_gain = ch1_ref_q[REF_GAIN];
  assign ch2_pump_gain = ch2_ref_q[REF_GAIN];
  assign ch1_detector_polarity = ch1_ref_q[REF_POL];
  assign ch2_detector_polarity = ch2_ref_q[REF_POL];

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  property p_shift;
    @(posedge clk) disable iff (!rst_b_sync)
    sclk_rise |=> shift_q == {$past(shift_q[WORD_W-2:0]), $past(sdata_lvl)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong"); // RULE1

  property p_hold;
    @(posedge clk) disable iff (!rst_b_sync)
    !le_rise |=> $stable(ch1_fb_q) && $stable(ch2_fb_q)
      && $stable(ch1_ref_q) && $stable(ch2_ref_q);
  endproperty
  a_hold: assert property (p_hold) else $error("latch moved"); // RULE16

  property p_ch2ref;
    @(posedge clk) disable iff (!rst_b_sync)
    le_rise && shift_q[1:0] == 2'b00 |=>
      ch2_ref_q[21:17] == $past(shift_q[21:17]) && $stable(ch1_ref_q);
  endproperty
  a_ch2ref: assert property (p_ch2ref) else $error("ch2 ref load"); // RULE6

  property p_ch2fb;
    @(posedge clk) disable iff (!rst_b_sync)
    le_rise && shift_q[1:0] == 2'b01 |=>
      ch2_fb_q[21:9] == $past(shift_q[21:9]) && $stable(ch2_ref_q);
  endproperty
  a_ch2fb: assert property (p_ch2fb) else $error("ch2 fb load"); // RULE8

  property p_ch1ref;
    @(posedge clk) disable iff (!rst_b_sync)
    le_rise && shift_q[1:0] == 2'b10 |=>
      ch1_ref_div == $past(shift_q[15:2]) && $stable(ch2_ref_q);
  endproperty
  a_ch1ref: assert property (p_ch1ref) else $error("ch1 ref load"); // RULE7

  property p_ch1fb;
    @(posedge clk) disable iff (!rst_b_sync)
    le_rise && shift_q[1:0] == 2'b11 |=>
      ch1_fb_q[7:2] == $past(shift_q[7:2]) && $stable(ch2_fb_q);
  endproperty
  a_ch1fb: assert property (p_ch1fb) else $error("ch1 fb load"); // RULE9

  property p_unused;
    @(posedge clk) disable iff (!rst_b_sync)
    ch1_ref_q[16] == 1'b0 && ch2_ref_q[16] == 1'b0
      && ch1_fb_q[8] == 1'b0 && ch2_fb_q[8] == 1'b0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit"); // RULE17

  property p_ratio;
    @(posedge clk) disable iff (!rst_b_sync)
    $stable(ch1_fb_q) ##1 $stable(ch1_fb_q) |-> ch1_feedback_ratio ==
      FB_W'((ch1_fb_q[20] ? 65'd64 : 65'd32) * ch1_fb_q[19:9]
      + ch1_fb_q[7:2]);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio wrong"); // RULE14

  property p_lock;
    @(posedge clk) disable iff (!rst_b_sync)
    mon_sel == 4'b0100 && lock2_lvl |=> monitor_output_oe_b;
  endproperty
  a_lock: assert property (p_lock) else $error("lock pin low"); // RULE11

  c_load1: cover property (@(posedge clk) le_rise && sel == DSL_CH1_FB);
  c_load2: cover property (@(posedge clk) le_rise && sel == DSL_CH2_REF);
  c_lock: cover property (@(posedge clk) mon_sel == 4'b0100 && lock2_lvl);
endmodule

// ==== inc/dsl_pkg.sv ====
// constants and types for the dual synthesizer serial latch loader
// ----------------------------------------------------------------------
// Summary of operation
// RULE1: each rising serial clock edge shifts one data bit into a 22-bit register; the host sets the bit up before that edge.
// RULE2: the host sends each word most significant bit first, so the two select bits arrive last.
// RULE3: a rising load strobe edge copies the shift register into exactly one of four latches.
// RULE4: the destination comes from word bits one (upper) and zero (lower).
// RULE5: code 00 picks ch2 reference, 01 ch2 feedback, 10 ch1 reference, 11 ch1 feedback.
// RULE6: ch2 reference latch holds monitor high 21, monitor low 20, tristate 19, gain 18, polarity 17, unused 16, divider 15..2.
// RULE7: ch1 reference latch uses the same placement, its control bits acting on channel one.
// RULE8: ch2 feedback latch holds power-down 21, prescaler 20, base count 19..9, unused 8, swallow count 7..2.
// RULE9: ch1 feedback latch uses the same layout as the ch2 feedback latch.
// RULE10: the monitor output source is chosen from the two top bits of both reference latches.
// RULE11: in lock mode the monitor output is open drain, high while locked apart from short low pulses.
// RULE12: each feedback divider is 17 bits (6-bit swallow plus 11-bit base); reference divider is 14 bits.
// RULE13: the host programs reference ratios from 1 to 16383, never zero.
// RULE14: each prescaler select bit picks 32/33 or 64/65 for its channel.
// RULE15: the host programs base counts 1 to 2047 and swallow counts 0 to 63.
// RULE16: shifting never alters a latch; latches change only on a load strobe that addresses them.
// RULE17: unused latch bits are ignored and affect nothing.
// ----------------------------------------------------------------------
package dsl_pkg;
  localparam int WORD_W = 22;
  localparam int REF_W = 14;
  localparam int BASE_W = 11;
  localparam int SWAL_W = 6;
  localparam int FB_W = 17;
  // reference latch fields
  localparam int REF_MON_HI = 21;
  localparam int REF_MON_LO = 20;
  localparam int REF_TRI = 19;
  localparam int REF_GAIN = 18;
  localparam int REF_POL = 17;
  localparam int REF_DIV_MSB = 15;
  // feedback latch fields
  localparam int FB_PWRDN = 21;
  localparam int FB_PRESC = 20;
  localparam int FB_BASE_MSB = 19;
  localparam int FB_BASE_LSB = 9;
  localparam int FB_SWAL_MSB = 7;
  localparam int FIELD_LSB = 2;
  localparam logic [21:0] LATCH_RST = 22'h00_0000;
  // prescaler moduli
  localparam logic [6:0] PRESC_32 = 7'h20;
  localparam logic [6:0] PRESC_64 = 7'h40;
  localparam logic [1:0] MON_CH2_LOCK = 2'h1;
  typedef enum logic [1:0] {
    DSL_CH2_REF = 2'b00,
    DSL_CH2_FB = 2'b01,
    DSL_CH1_REF = 2'b10,
    DSL_CH1_FB = 2'b11
  } dsl_sel_e;
endpackage

// ==== tb/dsl_host.sv ====
// host model driving the three-wire programming link
`timescale 1ns/1ps
module dsl_host (
  // system clock used to pace the link
  input wire logic clk,
  // serial link
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // shift a word msb first, link clock idle low between frames
  task automatic send(input logic [21:0] w, input logic load);
    for (int i = 21; i >= 0; i--) begin
      serial_data = w[i];
      wait_clk(4);
      serial_clk = 1'b1;
      wait_clk(4);
      serial_clk = 1'b0;
    end
    wait_clk(4);
    // hold time is over, so the line no longer shows the last bit
    serial_data = ~w[0];
    if (load) begin
      load_strobe = 1'b1;
      wait_clk(8);
      load_strobe = 1'b0;
    end
    wait_clk(8);
  endtask
endmodule

// ==== tb/dsl_loader_tb.sv ====
// self-checking bench for the serial latch loader
`timescale 1ns/1ps
module dsl_loader_tb;
  import dsl_pkg::*;
  logic clk, rst_b, serial_clk, serial_data, load_strobe;
  logic ch1_lock, ch2_lock, monitor_output_o, monitor_output_oe_b, pin;
  logic [REF_W-1:0] ch1_ref_div, ch2_ref_div;
  logic [BASE_W-1:0] ch1_base_count, ch2_base_count;
  logic [SWAL_W-1:0] ch1_swallow_count, ch2_swallow_count;
  logic [FB_W-1:0] ch1_feedback_ratio, ch2_feedback_ratio;
  logic ch1_prescaler_select, ch1_power_down, ch1_pump_tristate;
  logic ch1_pump_gain, ch1_detector_polarity;
  logic ch2_prescaler_select, ch2_power_down, ch2_pump_tristate;
  logic ch2_pump_gain, ch2_detector_polarity;
  logic [16:0] ref1, ref2;
  logic [18:0] fb1, fb2;
  logic [21:0] lt [4];
  logic [21:0] corner [4];
  logic [21:0] w;
  logic [31:0] rnd;
  logic exp_pin;
  int error_cnt, comparisons, cycles;

  dsl_host u_host (.clk, .serial_clk, .serial_data, .load_strobe);

  dsl_loader dut (.clk, .rst_b, .serial_clk, .serial_data, .load_strobe,
    .ch1_lock, .ch2_lock, .monitor_output_o, .monitor_output_oe_b,
    .ch1_ref_div, .ch1_base_count, .ch1_swallow_count, .ch1_feedback_ratio,
    .ch1_prescaler_select, .ch1_power_down, .ch1_pump_tristate,
    .ch1_pump_gain, .ch1_detector_polarity,
    .ch2_ref_div, .ch2_base_count, .ch2_swallow_count, .ch2_feedback_ratio,
    .ch2_prescaler_select, .ch2_power_down, .ch2_pump_tristate,
    .ch2_pump_gain, .ch2_detector_polarity);

  // open-drain pin with pull-up
  assign pin = monitor_output_oe_b ? 1'b1 : monitor_output_o;
  assign ref1 = {ch1_pump_tristate, ch1_pump_gain, ch1_detector_polarity,
    ch1_ref_div};
  assign ref2 = {ch2_pump_tristate, ch2_pump_gain, ch2_detector_polarity,
    ch2_ref_div};
  assign fb1 = {ch1_power_down, ch1_prescaler_select, ch1_base_count,
    ch1_swallow_count};
  assign fb2 = {ch2_power_down, ch2_prescaler_select, ch2_base_count,
    ch2_swallow_count};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic [16:0] ratio(input logic [21:0] f);
    return (f[20] ? 17'd64 : 17'd32) * f[19:9] + f[7:2];
  endfunction

  function automatic logic mon_exp(input logic [1:0] s2, input logic [1:0] s1,
                                   input logic l1, input logic l2);
    if (s1 != 2'b00) return l1 & l2;
    case (s2)
      2'b01: return l2;
      2'b10: return l1;
      2'b11: return l1 & l2;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [21:0] gen(input logic [1:0] c);
    logic [21:0] v;
    repeat (22) rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    v = {rnd[21:2], c};
    if (!c[0] && v[15:2] == 14'h0) v[2] = 1'b1;
    if (c[0] && v[19:9] == 11'h0) v[9] = 1'b1;
    return v;
  endfunction

  task automatic check_all();
    chk("ch2_ref", ref2, {lt[0][19:17], lt[0][15:2]});
    chk("ch2_fb", fb2, {lt[1][21:9], lt[1][7:2]});
    chk("ch2_ratio", ch2_feedback_ratio, ratio(lt[1]));
    chk("ch1_ref", ref1, {lt[2][19:17], lt[2][15:2]});
    chk("ch1_fb", fb1, {lt[3][21:9], lt[3][7:2]});
    chk("ch1_ratio", ch1_feedback_ratio, ratio(lt[3]));
  endtask

  task automatic load(input logic [21:0] v);
    u_host.send(v, 1'b1);
    lt[v[1:0]] = v;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      $display("timeout");
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    ch1_lock = 1'b0;
    ch2_lock = 1'b0;
    rnd = 32'h0000_e5d7;
    corner = '{22'h3f_fffc, 22'h00_0201, 22'h00_0006, 22'h3f_ffff};
    for (int i = 0; i < 4; i++) lt[i] = 22'h00_0000;
    repeat (10) @(posedge clk);
    #1;
    chk("pin_in_reset", pin, 1'b0);
    rst_b = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check_all();
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      load(corner[i]);
      check_all();
    end
    $display("test boundary values done");
    for (int i = 0; i < 24; i++) begin
      w = gen(rnd[5:4] ^ i[1:0]);
      load(w);
      check_all();
    end
    $display("test random loads done");
    u_host.send(gen(2'b11), 1'b0);
    u_host.send(gen(2'b00), 1'b0);
    check_all();
    $display("test shift without load done");
    for (int m = 0; m < 16; m++) begin
      w = gen(2'b00);
      w[21:20] = m[1:0];
      load(w);
      w = gen(2'b10);
      w[21:20] = m[3:2];
      load(w);
      for (int k = 0; k < 4; k++) begin
        ch1_lock = k[0];
        ch2_lock = k[1];
        repeat (6) @(posedge clk);
        #1;
        exp_pin = mon_exp(lt[0][21:20], lt[2][21:20], k[0], k[1]);
        chk("monitor_pin", pin, exp_pin);
      end
    end
    $display("test monitor select done");
    // reset in mid-run clears every latch and pulls the pin low
    rst_b = 1'b0;
    for (int i = 0; i < 4; i++) lt[i] = LATCH_RST;
    repeat (2) @(posedge clk);
    #1;
    chk("pin_mid_reset", pin, 1'b0);
    check_all();
    rst_b = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    load(corner[3]);
    check_all();
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
